// *** common/strr_cfg.svh ***
`ifndef STRR_CFG_SVH
`define STRR_CFG_SVH

// clock and time figures
`define STRR_CLK_MHZ 250
`define STRR_LAMP_MS 1000
`define STRR_FLASH_MS 250
`define STRR_DEB_MS 10

// subtest numbers
`define STRR_HDC_FIRST 7'h01
`define STRR_HDC_LAST 7'h07
`define STRR_LIM_RAM 7'h03
`define STRR_LIM_DMA 7'h05
`define STRR_LIM_TIMER 7'h06
`define STRR_DRV_FIRST 7'h0a
`define STRR_SERVO_FIRST 7'h13
`define STRR_POS_FIRST 7'h1d
`define STRR_RW_FIRST 7'h26
`define STRR_ERR_FIRST 7'h5f
`define STRR_DRV_LAST 7'h65
`define STRR_PN_TRIGGER 7'h26
`define STRR_PN_FIRST 7'h66
`define STRR_PN_LAST 7'h68
`define STRR_PN_RESUME 7'h27
`define STRR_NO_TEST 7'h00

// readout glyph codes; 5'h00 to 5'h0f are hex digits
`define STRR_G_BLANK 5'h10
`define STRR_G_PASS 5'h11
`define STRR_G_FAIL 5'h12
`define STRR_G_UNIT 5'h13
`define STRR_G_ASSY 5'h14
`define STRR_G_REL_R 5'h15
`define STRR_G_REL_D 5'h16
`define STRR_G_EIGHT 5'h08
`define STRR_HDC_LABEL 5'h02

`endif

// *** common/strr_pkg.sv ***
package strr_pkg;

    typedef enum logic [2:0] {
        ST_LAMP = 3'b000,
        ST_HDC = 3'b001,
        ST_DRV = 3'b011,
        ST_DONE = 3'b010,
        ST_HALT = 3'b110
    } strr_state_t;

    typedef enum logic [2:0] {
        STP_PF = 3'b000,
        STP_UNIT = 3'b001,
        STP_A1 = 3'b011,
        STP_A2 = 3'b010,
        STP_TEST = 3'b110
    } strr_step_t;

    typedef logic [4:0] strr_glyph_t;

    typedef struct packed {
        logic fail;
        logic [2:0] assy1;
        logic [2:0] assy2;
        logic [6:0] test;
    } strr_unit_t;

endpackage

// *** common/strr_btn_if.sv ***
interface strr_btn_if;
    logic raw;
    logic level;
    logic pressed;
    logic released;
    modport deb (input raw, output level, output pressed, output released);
    modport user (output raw, input level, input pressed, input released);
endinterface

// *** verilog/strr_debounce.sv ***
module strr_debounce #(
    parameter int unsigned DEB_CYC = 2500000
) (
    input wire logic clk,
    input wire logic rst_b,
    strr_btn_if.deb btn
);
    logic sync1_reg;
    logic sync2_reg;
    logic level_reg;
    logic pressed_reg;
    logic released_reg;
    logic [31:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= btn.raw;
            sync2_reg <= sync1_reg;
        end
    end

    // level only moves after the synchronised input has held still for DEB_CYC cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 32'h0;
            level_reg <= 1'b0;
            pressed_reg <= 1'b0;
            released_reg <= 1'b0;
        end else begin
            pressed_reg <= 1'b0;
            released_reg <= 1'b0;
            if (sync2_reg == level_reg) begin
                cnt_reg <= 32'h0;
            end else if (cnt_reg == DEB_CYC - 1) begin
                cnt_reg <= 32'h0;
                level_reg <= sync2_reg;
                pressed_reg <= sync2_reg;
                released_reg <= !sync2_reg;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    assign btn.level = level_reg;
    assign btn.pressed = pressed_reg;
    assign btn.released = released_reg;
endmodule

// *** verilog/strr_top.sv ***
// Contract
// - no on line unless host-side controller passed
// - drive-side failure only reported, not blocking
// - run at power on, button, host command
// - subtests run in seven ordered groups
// - button or host runs limited controller set
// - product number subtests follow passed 26
// - lamp test then flashing green while running; a host-started run skips the lamp test and flashes green from the start
// - controller failure holds solid red and green
// - done: solid green pass, solid red fail
// - pass or fail glyph with bus address
// - step through units in turn
// - controller shown as unit 2
// - suspects most probable first, then subtest
// - first digit glyph codes per kind
// - failed subtest shown as two hex digits
// - passed unit skips straight to next unit
// - log run-time faults after power on
// - status request returns self-test failure details
// - after last result return to pass/fail
// - button requests release; denial shown while held
`include "strr_cfg.svh"

module strr_top
    import strr_pkg::*;
#(
    parameter int unsigned LAMP_CYC = `STRR_LAMP_MS * `STRR_CLK_MHZ * 1000,
    parameter int unsigned FLASH_CYC = `STRR_FLASH_MS * `STRR_CLK_MHZ * 1000,
    parameter int unsigned DEB_CYC = `STRR_DEB_MS * `STRR_CLK_MHZ * 1000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] bus_addr,
    input wire logic test_btn_raw,
    input wire logic result_btn_raw,
    input wire logic host_diag,
    input wire logic host_stat_req,
    input wire logic release_grant,
    input wire logic release_deny,
    input wire logic test_done,
    input wire logic test_pass,
    input wire logic [2:0] test_suspect1,
    input wire logic [2:0] test_suspect2,
    input wire logic rt_fault,
    input wire logic [7:0] rt_code,
    output logic test_start,
    output logic [6:0] test_num,
    output logic test_limited,
    output logic [2:0] test_group,
    output logic led_red,
    output logic led_green,
    output strr_glyph_t dig_hi,
    output strr_glyph_t dig_lo,
    output logic release_req,
    output logic online,
    output logic stat_valid,
    output logic stat_diag_fail,
    output logic [2:0] stat_p1,
    output logic [2:0] stat_p2,
    output logic [6:0] stat_p3,
    output logic [7:0] log_count,
    output logic [7:0] log_last
);

    function automatic strr_glyph_t strr_hex(input logic [3:0] nib);
        strr_hex = {1'b0, nib};
    endfunction
    // the limited set skips the tests that would wipe the runtime state
    function automatic logic [6:0] strr_next(input logic [6:0] num, input logic lim);
        strr_next = (lim && num == `STRR_LIM_RAM) ? `STRR_LIM_DMA :
            (lim && num == `STRR_LIM_DMA) ? `STRR_LIM_TIMER :
            (lim && num == `STRR_LIM_TIMER) ? `STRR_NO_TEST :
            (num == `STRR_HDC_LAST || num == `STRR_DRV_LAST) ? `STRR_NO_TEST :
            (num == `STRR_PN_TRIGGER) ? `STRR_PN_FIRST :
            (num == `STRR_PN_LAST) ? `STRR_PN_RESUME :
            num + 7'h01;
    endfunction

    function automatic logic [2:0] strr_group(input logic [6:0] num);
        strr_group = num < `STRR_DRV_FIRST ? 3'h0 :
            num < `STRR_SERVO_FIRST ? 3'h1 :
            num < `STRR_POS_FIRST ? 3'h2 :
            num < `STRR_RW_FIRST ? 3'h3 :
            num < `STRR_ERR_FIRST ? 3'h4 :
            num <= `STRR_DRV_LAST ? 3'h5 : 3'h6;
    endfunction

    strr_btn_if tbtn ();
    strr_btn_if rbtn ();
    assign tbtn.raw = test_btn_raw;
    assign rbtn.raw = result_btn_raw;

    strr_debounce #(.DEB_CYC(DEB_CYC)) u_test_deb (
        .clk(clk),
        .rst_b(rst_b),
        .btn(tbtn)
    );
    strr_debounce #(.DEB_CYC(DEB_CYC)) u_result_deb (
        .clk(clk),
        .rst_b(rst_b),
        .btn(rbtn)
    );

    strr_state_t state_reg;
    strr_step_t step_reg;
    logic step_u_reg;
    strr_unit_t unit_reg [0:1];
    logic run_lim_reg;
    logic show8_reg;
    logic [31:0] lamp_cnt_reg;
    logic [31:0] flash_cnt_reg;
    logic flash_reg;
    logic [6:0] test_num_reg;
    logic wait_reg;
    logic start_reg;
    logic grant_reg;
    logic deny_reg;
    logic red_reg;
    logic green_reg;
    strr_glyph_t hi_reg;
    strr_glyph_t lo_reg;
    logic stat_valid_reg;
    logic stat_fail_reg;
    logic [2:0] stat_p1_reg;
    logic [2:0] stat_p2_reg;
    logic [6:0] stat_p3_reg;
    logic [7:0] log_count_reg;
    logic [7:0] log_last_reg;
    logic pressed_any;
    logic running;
    logic any_fail;
    logic btn_start;
    logic do_start;
    logic adv;
    logic fail_now;
    assign pressed_any = tbtn.level | rbtn.level;
    assign running = state_reg == ST_LAMP || state_reg == ST_HDC || state_reg == ST_DRV;
    assign any_fail = unit_reg[0].fail | unit_reg[1].fail;
    assign btn_start = tbtn.released && grant_reg;
    // a halted controller takes no start; a start is taken whenever the readout is on pass/fail, even mid-run
    assign do_start = state_reg != ST_HALT && step_reg == STP_PF && (btn_start || host_diag);
    assign fail_now = wait_reg && test_done && !test_pass && (state_reg == ST_HDC || state_reg == ST_DRV);
    assign adv = rbtn.released && (state_reg == ST_HALT || (state_reg == ST_DONE && grant_reg));

    // grant and denial are caught while a button is held and dropped when it lets go
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grant_reg <= 1'b0;
            deny_reg <= 1'b0;
        end else begin
            grant_reg <= pressed_any && (grant_reg || release_grant);
            deny_reg <= pressed_any && (deny_reg || release_deny);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_LAMP;
            run_lim_reg <= 1'b0;
            show8_reg <= 1'b1;
            lamp_cnt_reg <= 32'h0;
            test_num_reg <= `STRR_HDC_FIRST;
            wait_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (do_start) begin
                state_reg <= host_diag ? ST_HDC : ST_LAMP;
                show8_reg <= !host_diag;
                lamp_cnt_reg <= 32'h0;
                run_lim_reg <= 1'b1;
                test_num_reg <= `STRR_LIM_RAM;
                wait_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_LAMP: begin
                        if (lamp_cnt_reg == LAMP_CYC - 1) begin
                            state_reg <= ST_HDC;
                            show8_reg <= 1'b0;
                            lamp_cnt_reg <= 32'h0;
                        end else begin
                            lamp_cnt_reg <= lamp_cnt_reg + 32'h1;
                        end
                    end
                    ST_HDC, ST_DRV: begin
                        if (!wait_reg) begin
                            start_reg <= 1'b1;
                            wait_reg <= 1'b1;
                        end else if (test_done) begin
                            wait_reg <= 1'b0;
                            if (!test_pass) begin
                                state_reg <= state_reg == ST_HDC ? ST_HALT : ST_DONE;
                            end else if (strr_next(test_num_reg, run_lim_reg) != `STRR_NO_TEST) begin
                                test_num_reg <= strr_next(test_num_reg, run_lim_reg);
                            end else if (state_reg == ST_HDC) begin
                                state_reg <= ST_DRV;
                                test_num_reg <= `STRR_DRV_FIRST;
                            end else begin
                                state_reg <= ST_DONE;
                            end
                        end
                    end
                    ST_DONE, ST_HALT: wait_reg <= 1'b0;
                    default: state_reg <= ST_LAMP;
                endcase
            end
        end
    end

    // per-unit results; index 1 holds the host-side controller
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            unit_reg[0] <= '0;
            unit_reg[1] <= '0;
        end else if (do_start) begin
            unit_reg[0] <= '0;
            unit_reg[1] <= '0;
        end else if (fail_now) begin
            unit_reg[state_reg == ST_HDC] <= '{fail: 1'b1, assy1: test_suspect1,
                                              assy2: test_suspect2, test: test_num_reg};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_reg <= STP_PF;
            step_u_reg <= 1'b0;
        end else if (adv) begin
            unique case (step_reg)
                STP_PF: begin
                    step_reg <= STP_UNIT;
                    step_u_reg <= 1'b0;
                end
                STP_UNIT: begin
                    if (!unit_reg[step_u_reg].fail) begin
                        step_reg <= step_u_reg ? STP_PF : STP_UNIT;
                        step_u_reg <= 1'b1;
                    end else begin
                        step_reg <= unit_reg[step_u_reg].assy1 != 3'h0 ? STP_A1 : STP_TEST;
                    end
                end
                STP_A1: step_reg <= unit_reg[step_u_reg].assy2 != 3'h0 ? STP_A2 : STP_TEST;
                STP_A2: step_reg <= STP_TEST;
                STP_TEST: begin
                    step_reg <= step_u_reg ? STP_PF : STP_UNIT;
                    step_u_reg <= 1'b1;
                end
                default: step_reg <= STP_PF;
            endcase
        end
    end

    // flash prescaler; only meaningful while a run is in progress
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_cnt_reg <= 32'h0;
            flash_reg <= 1'b0;
        end else if (flash_cnt_reg == FLASH_CYC - 1) begin
            flash_cnt_reg <= 32'h0;
            flash_reg <= !flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            red_reg <= 1'b0;
            green_reg <= 1'b0;
        end else begin
            red_reg <= state_reg == ST_LAMP || state_reg == ST_HALT ||
                (state_reg == ST_DONE && any_fail);
            green_reg <= state_reg == ST_LAMP || state_reg == ST_HALT || (state_reg == ST_DONE && !any_fail) ||
                (running && flash_reg);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_reg <= `STRR_G_BLANK;
            lo_reg <= `STRR_G_BLANK;
        end else if (running) begin
            hi_reg <= state_reg == ST_LAMP && show8_reg ? `STRR_G_EIGHT : `STRR_G_BLANK;
            lo_reg <= state_reg == ST_LAMP && show8_reg ? `STRR_G_EIGHT : `STRR_G_BLANK;
        end else if (pressed_any && state_reg != ST_HALT) begin
            hi_reg <= deny_reg ? `STRR_G_REL_R : `STRR_G_BLANK;
            lo_reg <= deny_reg ? `STRR_G_REL_D : `STRR_G_BLANK;
        end else begin
            unique case (step_reg)
                STP_PF: begin
                    hi_reg <= any_fail ? `STRR_G_FAIL : `STRR_G_PASS;
                    lo_reg <= {2'b00, bus_addr};
                end
                STP_UNIT: begin
                    hi_reg <= `STRR_G_UNIT;
                    lo_reg <= step_u_reg ? `STRR_HDC_LABEL : 5'h00;
                end
                STP_A1, STP_A2: begin
                    hi_reg <= `STRR_G_ASSY;
                    lo_reg <= {2'b00, step_reg == STP_A1 ? unit_reg[step_u_reg].assy1 : unit_reg[step_u_reg].assy2};
                end
                STP_TEST: begin
                    hi_reg <= strr_hex({1'b0, unit_reg[step_u_reg].test[6:4]});
                    lo_reg <= strr_hex(unit_reg[step_u_reg].test[3:0]);
                end
                default: begin
                    hi_reg <= `STRR_G_BLANK;
                    lo_reg <= `STRR_G_BLANK;
                end
            endcase
        end
    end

    // status answer; a halted controller is deaf to the host
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_valid_reg <= 1'b0;
            stat_fail_reg <= 1'b0;
            stat_p1_reg <= 3'h0;
            stat_p2_reg <= 3'h0;
            stat_p3_reg <= 7'h00;
        end else begin
            stat_valid_reg <= host_stat_req && state_reg != ST_HALT;
            if (host_stat_req) begin
                stat_fail_reg <= any_fail;
                stat_p1_reg <= unit_reg[unit_reg[1].fail].assy1;
                stat_p2_reg <= unit_reg[unit_reg[1].fail].assy2;
                stat_p3_reg <= unit_reg[0].test;
            end
        end
    end

    // run-time fault log, counter saturates rather than wrapping
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            log_count_reg <= 8'h00;
            log_last_reg <= 8'h00;
        end else if (rt_fault) begin
            log_last_reg <= rt_code;
            log_count_reg <= log_count_reg + {7'h00, log_count_reg != 8'hff};
        end
    end

    assign test_start = start_reg;
    assign test_num = test_num_reg;
    assign test_limited = run_lim_reg;
    assign test_group = strr_group(test_num_reg);
    assign led_red = red_reg;
    assign led_green = green_reg;
    assign dig_hi = hi_reg;
    assign dig_lo = lo_reg;
    assign release_req = state_reg != ST_HALT && (pressed_any || step_reg != STP_PF);
    assign online = state_reg == ST_DONE && !unit_reg[1].fail && !release_req;
    assign stat_valid = stat_valid_reg;
    assign stat_diag_fail = stat_fail_reg;
    assign stat_p1 = stat_p1_reg;
    assign stat_p2 = stat_p2_reg;
    assign stat_p3 = stat_p3_reg;
    assign log_count = log_count_reg;
    assign log_last = log_last_reg;
endmodule

// *** dv/strr_engine_model.sv ***
module strr_engine_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic test_start,
    input wire logic [6:0] test_num,
    input wire logic [6:0] fail_num,
    input wire logic slow,
    output logic test_done,
    output logic test_pass,
    output logic [2:0] test_suspect1,
    output logic [2:0] test_suspect2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] seen_q[$];
    logic [6:0] num;
    int cnt;
    // qualifiers toggle when idle to expose stale use
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt = 0;
            test_done <= 1'b0;
            test_pass <= 1'b0;
            test_suspect1 <= 3'h0;
            test_suspect2 <= 3'h0;
        end else begin
            test_done <= 1'b0;
            test_pass <= ~test_pass;
            test_suspect1 <= ~test_suspect1;
            test_suspect2 <= ~test_suspect2;
            if (test_start) begin
                cnt = slow ? 7 : 1;
                num = test_num;
                seen_q.push_back(test_num);
            end else if (cnt > 0) begin
                cnt = cnt - 1;
                if (cnt == 0) begin
                    test_done <= 1'b1;
                    test_pass <= (num !== fail_num);
                    test_suspect1 <= 3'h4;
                    test_suspect2 <= 3'h2;
                end
            end
        end
    end
endmodule

// *** dv/strr_top_properties.sv ***
`include "strr_cfg.svh"

module strr_top_properties
    import strr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] bus_addr,
    input wire logic host_stat_req,
    input wire logic test_start,
    input wire logic [6:0] test_num,
    input wire logic test_limited,
    input wire logic [2:0] test_group,
    input wire logic led_red,
    input wire logic led_green,
    input wire strr_glyph_t dig_hi,
    input wire strr_glyph_t dig_lo,
    input wire logic release_req,
    input wire logic online,
    input wire logic stat_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [6:0] last_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_reg <= 7'h00;
        end else if (test_start) begin
            last_reg <= test_num;
        end
    end
    property p_online;
        online |-> !release_req && !(led_red && led_green);
    endproperty
    a_online: assert property (p_online) else $error("online while not allowed");
    property p_group;
        test_start |-> ((test_num <= 7'h07) == (test_group == 3'h0));
    endproperty
    a_group: assert property (p_group) else $error("group mismatch");
    property p_limited;
        test_start && test_limited && test_num < 7'h0a |-> test_num inside {7'h03, 7'h05, 7'h06};
    endproperty
    a_limited: assert property (p_limited) else $error("limited set broken");
    property p_pn;
        test_start && test_num == 7'h66 |-> last_reg == 7'h26;
    endproperty
    a_pn: assert property (p_pn) else $error("product check out of place");
    property p_resume;
        test_start && test_num == 7'h27 |-> last_reg == 7'h68;
    endproperty
    a_resume: assert property (p_resume) else $error("resume out of place");
    property p_pf;
        dig_hi inside {`STRR_G_PASS, `STRR_G_FAIL} |-> dig_lo == {2'b00, bus_addr};
    endproperty
    a_pf: assert property (p_pf) else $error("address digit wrong");
    property p_unit;
        dig_hi == `STRR_G_UNIT |-> dig_lo inside {5'h00, 5'h02};
    endproperty
    a_unit: assert property (p_unit) else $error("unit digit wrong");
    property p_assy;
        dig_hi == `STRR_G_ASSY |-> dig_lo inside {[5'h01:5'h06]};
    endproperty
    a_assy: assert property (p_assy) else $error("assembly digit wrong");
    property p_stat;
        host_stat_req && !(led_red && led_green) |=> stat_valid;
    endproperty
    a_stat: assert property (p_stat) else $error("status not answered");
endmodule

bind strr_top strr_top_properties i_props (.*);

// *** dv/strr_top_tb.sv ***
`include "strr_cfg.svh"

module strr_top_tb
    import strr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic test_btn_raw = 1'b0;
    logic result_btn_raw = 1'b0;
    logic host_diag = 1'b0;
    logic host_stat_req = 1'b0;
    logic release_grant = 1'b0;
    logic release_deny = 1'b0;
    logic rt_fault = 1'b0;
    logic [7:0] rt_code = 8'h00;
    logic [2:0] bus_addr = 3'h5;
    logic [6:0] fail_num = 7'h7f;
    logic slow = 1'b0;
    logic test_start, test_limited, test_done, test_pass, led_red, led_green, online, stat_valid;
    logic release_req, stat_diag_fail;
    logic [6:0] test_num, stat_p3;
    logic [2:0] test_suspect1, test_suspect2, stat_p1, stat_p2, test_group;
    logic [7:0] log_count, log_last;
    strr_glyph_t dig_hi, dig_lo;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    // short counts keep the run small
    strr_top #(.LAMP_CYC(20), .FLASH_CYC(8), .DEB_CYC(4)) i_dut (.*);
    strr_engine_model i_eng (.*);

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_dig(input strr_glyph_t hi, input strr_glyph_t lo);
        chk("dig_hi", 8'(hi), 8'(dig_hi));
        chk("dig_lo", 8'(lo), 8'(dig_lo));
    endtask

    task automatic chk_led(input logic r, input logic g);
        chk("led_red", 8'(r), 8'(led_red));
        chk("led_green", 8'(g), 8'(led_green));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hold past sync and debounce on both edges
    task automatic press(input bit res, input bit g, input bit d);
        @(posedge clk);
        release_grant <= g;
        release_deny <= d;
        result_btn_raw <= res;
        test_btn_raw <= !res;
        tick(14);
        if (d)
            chk_dig(`STRR_G_REL_R, `STRR_G_REL_D);
        @(posedge clk);
        result_btn_raw <= 1'b0;
        test_btn_raw <= 1'b0;
        release_grant <= 1'b0;
        release_deny <= 1'b0;
        tick(16);
    endtask

    task automatic wait_res();
        int n = 0;
        while (dig_hi !== `STRR_G_PASS && dig_hi !== `STRR_G_FAIL && n < 5000) begin
            tick(1);
            n++;
        end
        chk("result ready", 8'h01, 8'(n < 5000));
    endtask

    task automatic chk_order(input bit lim, input logic [6:0] fail);
        logic [6:0] e[$];
        int i;
        if (lim)
            e = '{7'h03, 7'h05, 7'h06};
        else
            for (i = 1; i <= 7; i++) e.push_back(7'(i));
        for (i = 'h0a; i <= 'h65; i++) begin
            e.push_back(7'(i));
            if (i == 'h26)
                e = {e, 7'h66, 7'h67, 7'h68};
        end
        for (i = 0; i < e.size(); i++)
            if (e[i] === fail) e = e[0:i];
        chk("subtest count", 8'(e.size()), 8'(i_eng.seen_q.size()));
        for (i = 0; i < e.size(); i++) chk("subtest", {1'b0, e[i]}, {1'b0, i_eng.seen_q[i]});
    endtask

    task automatic t_power_on();
        bit g0 = 0;
        bit g1 = 0;
        bit r1 = 0;
        tick(2);
        chk_dig(5'h08, 5'h08);
        chk_led(1'b1, 1'b1);
        @(posedge clk);
        rt_fault <= 1'b1;
        rt_code <= 8'h3d;
        @(posedge clk);
        rt_code <= 8'hae;
        @(posedge clk);
        rt_fault <= 1'b0;
        tick(2);
        chk("log_count", 8'h02, log_count);
        chk("log_last", 8'hae, log_last);
        tick(20);
        repeat (20) begin
            tick(1);
            g0 |= (led_green === 1'b0);
            g1 |= (led_green === 1'b1);
            r1 |= (led_red !== 1'b0);
        end
        chk("green flashing", 8'h01, 8'(g0 & g1 & !r1));
        wait_res();
        chk_order(1'b0, 7'h7f);
        chk_dig(`STRR_G_PASS, 5'h05);
        chk_led(1'b0, 1'b1);
        chk("online", 8'h01, 8'(online));
        $display("test power_on done");
    endtask

    task automatic t_deny();
        i_eng.seen_q.delete();
        press(1'b0, 1'b0, 1'b1);
        chk_dig(`STRR_G_PASS, 5'h05);
        chk("no run", 8'h00, 8'(i_eng.seen_q.size()));
        $display("test deny done");
    endtask

    task automatic t_drive_fail();
        strr_glyph_t st[12] = '{`STRR_G_UNIT, 5'h00, `STRR_G_ASSY, 5'h04, `STRR_G_ASSY, 5'h02,
            5'h01, 5'h01, `STRR_G_UNIT, 5'h02, `STRR_G_FAIL, 5'h05};
        @(posedge clk);
        fail_num <= 7'h11;
        slow <= 1'b1;
        i_eng.seen_q.delete();
        press(1'b0, 1'b1, 1'b0);
        wait_res();
        chk_order(1'b1, 7'h11);
        chk_dig(`STRR_G_FAIL, 5'h05);
        chk_led(1'b1, 1'b0);
        chk("online", 8'h01, 8'(online));
        @(posedge clk);
        host_stat_req <= 1'b1;
        @(posedge clk);
        host_stat_req <= 1'b0;
        #1;
        chk("stat_valid", 8'h01, 8'(stat_valid));
        chk("stat_diag_fail", 8'h01, 8'(stat_diag_fail));
        chk("stat_p1", 8'h04, 8'(stat_p1));
        chk("stat_p2", 8'h02, 8'(stat_p2));
        chk("stat_p3", 8'h11, 8'(stat_p3));
        for (int k = 0; k < 6; k++) begin
            press(1'b1, 1'b1, 1'b0);
            chk_dig(st[2*k], st[2*k+1]);
            if (k == 0)
                chk("online stepping", 8'h00, 8'(online));
        end
        chk("online after", 8'h01, 8'(online));
        $display("test drive_fail done");
    endtask

    task automatic t_halt();
        strr_glyph_t st[12] = '{`STRR_G_UNIT, 5'h00, `STRR_G_UNIT, 5'h02, `STRR_G_ASSY, 5'h04,
            `STRR_G_ASSY, 5'h02, 5'h00, 5'h05, `STRR_G_FAIL, 5'h05};
        @(posedge clk);
        fail_num <= 7'h05;
        slow <= 1'b0;
        i_eng.seen_q.delete();
        host_diag <= 1'b1;
        @(posedge clk);
        host_diag <= 1'b0;
        tick(3);
        wait_res();
        chk_order(1'b1, 7'h05);
        chk_led(1'b1, 1'b1);
        chk("online", 8'h00, 8'(online));
        for (int k = 0; k < 6; k++) begin
            press(1'b1, 1'b1, 1'b0);
            chk_dig(st[2*k], st[2*k+1]);
        end
        press(1'b0, 1'b1, 1'b0);
        chk_dig(`STRR_G_FAIL, 5'h05);
        chk_led(1'b1, 1'b1);
        $display("test halt done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_power_on();
        t_deny();
        t_drive_fail();
        t_halt();
        conclude();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
endmodule
